// >>> core/ovd_params.svh
// Offsets, fields, resets and timing of the overlay decoder.
// Needs no other file.
`ifndef OVD_PARAMS_SVH
`define OVD_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths and spaces
// ----------------------------------------------------------------------
`define OVD_PM_WIDTH 24
`define OVD_DM_WIDTH 16
`define OVD_ADDR_WIDTH 14
`define OVD_PM_WORDS 16384
`define OVD_DM_WORDS 16384
`define OVD_OVL_WIDTH 4
`define OVD_EXT_OVL_1 4'h1
`define OVD_EXT_OVL_2 4'h2
`define OVD_MMR_BASE 14'h3FE0

// ----------------------------------------------------------------------
// Wishbone register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OVD_REG_CTRL 8'h00
`define OVD_REG_WAIT 8'h04
`define OVD_REG_STATUS 8'h08

// Core-side memory-mapped register indices, top of data memory
`define OVD_MMR_IDX_CTRL 5'h1F
`define OVD_MMR_IDX_WAIT 5'h1E

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define OVD_CTRL_PMOVL_LSB 0
`define OVD_CTRL_DMOVL_LSB 4
`define OVD_CTRL_HOST_BIT 8
`define OVD_CTRL_WMODE_BIT 9
`define OVD_CTRL_RESET 32'h0000_0000
`define OVD_WAIT_RESET 3'h7
`define OVD_STAT_REFUSED_BIT 1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OVD_SYNC_STAGES 2'h2
`define OVD_PM_EXT_WAITS 4'h0

`endif

// >>> core/ovd_pkg.sv
// Types shared by the memory overlay decoder and its user.
// Assumes the constants header is on the include path.
`include "ovd_params.svh"

package ovd_pkg;

  typedef enum logic [2:0] {
    OVD_ST_IDLE   = 3'b000,
    OVD_ST_INT    = 3'b001,
    OVD_ST_EXT    = 3'b010,
    OVD_ST_SYNC   = 3'b011,
    OVD_ST_DONE   = 3'b100,
    OVD_ST_REFUSE = 3'b101
  } ovd_state_t;

  // One core access: space, fetch flag, direction, address, write data
  typedef struct packed {
    logic pm_space;
    logic fetch;
    logic we;
    logic [`OVD_ADDR_WIDTH-1:0] addr;
    logic [`OVD_PM_WIDTH-1:0] wdata;
  } ovd_core_req_t;

  // External overlay bus as seen at the pins
  typedef struct packed {
    logic [`OVD_ADDR_WIDTH-1:0] addr;
    logic pms_n;
    logic dms_n;
    logic rd_n;
    logic wr_n;
    logic [`OVD_PM_WIDTH-1:0] data;
    logic [`OVD_PM_WIDTH-1:0] data_oe;
  } ovd_ext_bus_t;

endpackage

// >>> core/ovd_mem.sv
// On-chip RAM of one memory space, single port, registered read data.
// Assumes one access per cycle from the decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ovd_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16384,
  parameter int AW = 14
) (
  input wire logic clk_sys_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] rdata_out
);
  import ovd_pkg::*;

  logic [WIDTH-1:0] mem_q [DEPTH];

  // No reset on the array: RAM content is undefined at power-up
  always_ff @(posedge clk_sys_in) begin
    if (en_in && we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    if (en_in) begin
      rdata_out <= mem_q[addr_in];
    end
  end

endmodule

`default_nettype wire

// >>> core/ovd_wait.sv
// Wait-state down counter: loads a count, reports done when it reaches 0.
// Assumes start is a one-cycle pulse from the decoder.
`timescale 1ns/1ps
`default_nettype none

module ovd_wait (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [3:0] count_in,
  output logic done_out
);
  import ovd_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  assign cnt_d = start_in ? count_in : (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
  assign done_out = (cnt_q == 4'h0) && !start_in;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// >>> core/ovd_decoder.sv
// Memory overlay decoder: routes core program/data accesses to on-chip RAM,
// to the memory-mapped registers or to the two external overlay windows.
// Assumes a core that holds each request until ack, and a Wishbone master.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "ovd_params.svh"

// Summary of operation
// (RULE_01) Program memory is one 24-bit space for instructions and data.
// (RULE_02) On-chip program RAM holds up to 48K words, variant dependent.
// (RULE_03) Two external 8K program overlays sit on the external data bus.
// (RULE_04) Program select 1 or 2 sends 0x2000-0x3FFF outside, A13 low or high.
// (RULE_05) Data select 1 or 2 sends 0x0000-0x1FFF outside, A13 low or high.
// (RULE_06) Data memory is 16 bits wide; its top 32 words are control registers.
// (RULE_07) On-chip accesses finish in one cycle without wait states.
// (RULE_08) External data accesses stretch by the wait count and wait mode bit.
// (RULE_09) Host mode keeps the full data bus but drives only address bit A0. Here host-mode program accesses carry only 16 data bits.
// (RULE_10) Host mode keeps on-chip program memory; overlays get only A0.
// (RULE_11) Host mode refuses instruction fetch from external memory.
// (RULE_12) Host mode keeps on-chip data memory; data overlays get only A0.
// (RULE_13) Addresses outside the overlay window always go to on-chip memory.
module ovd_decoder (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Core access port
  input wire logic core_valid_in,
  input wire ovd_pkg::ovd_core_req_t core_req_in,
  output logic core_ack_out,
  output logic core_err_out,
  output logic [`OVD_PM_WIDTH-1:0] core_rdata_out,
  // External overlay bus
  output ovd_pkg::ovd_ext_bus_t ext_bus_out,
  input wire logic [`OVD_PM_WIDTH-1:0] ext_data_in
);
  import ovd_pkg::*;

  // --------------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------------
  logic [`OVD_OVL_WIDTH-1:0] program_overlay_select_q;
  logic [`OVD_OVL_WIDTH-1:0] data_overlay_select_q;
  logic host_mode_q;
  logic wait_mode_q;
  logic [2:0] data_wait_state_count_q;
  logic refused_q;
  logic last_ext_q;
  ovd_state_t state_q;
  ovd_state_t state_d;
  ovd_core_req_t req_q;
  logic req_ext_q;
  logic req_a13_q;
  logic [1:0] sync_cnt_q;
  logic [`OVD_PM_WIDTH-1:0] ext_data_s1_q;
  logic [`OVD_PM_WIDTH-1:0] ext_data_s2_q;
  logic [`OVD_PM_WIDTH-1:0] ext_rdata_q;
  logic [`OVD_DM_WIDTH-1:0] mmr_rdata_q;
  logic wb_ack_q;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire logic req_take = core_valid_in && (state_q == OVD_ST_IDLE);
  // (RULE_04) Program window test
  wire logic pm_in_window = core_req_in.addr[13];
  // (RULE_05) Data window test
  wire logic dm_in_window = !core_req_in.addr[13];
  wire logic pm_sel_ext = (program_overlay_select_q == `OVD_EXT_OVL_1) ||
                          (program_overlay_select_q == `OVD_EXT_OVL_2);
  wire logic dm_sel_ext = (data_overlay_select_q == `OVD_EXT_OVL_1) ||
                          (data_overlay_select_q == `OVD_EXT_OVL_2);
  // (RULE_13) Outside window stays on-chip
  wire logic pm_ext = core_req_in.pm_space && pm_in_window && pm_sel_ext;
  wire logic dm_ext = !core_req_in.pm_space && dm_in_window && dm_sel_ext;
  wire logic go_ext = pm_ext || dm_ext;
  // (RULE_06) Top 32 data words are registers
  wire logic go_mmr = !core_req_in.pm_space && (core_req_in.addr >= `OVD_MMR_BASE);
  // (RULE_11) No external fetch in host mode
  wire logic go_refuse = pm_ext && host_mode_q && core_req_in.fetch;
  wire logic [4:0] mmr_idx = core_req_in.addr[4:0];
  // (RULE_04) A13 from overlay number
  wire logic a13_sel = core_req_in.pm_space ?
                       (program_overlay_select_q == `OVD_EXT_OVL_2) :
                       (data_overlay_select_q == `OVD_EXT_OVL_2);

  // (RULE_08) Wait count with mode bit: doubled plus one when set
  wire logic [3:0] dm_waits = wait_mode_q ? {data_wait_state_count_q, 1'b1} :
                              {1'b0, data_wait_state_count_q};
  wire logic [3:0] ext_waits = core_req_in.pm_space ? `OVD_PM_EXT_WAITS : dm_waits;

  // --------------------------------------------------------------------
  // On-chip memories
  // --------------------------------------------------------------------
  // (RULE_07) On-chip access, one cycle
  wire logic int_go = req_take && !go_ext && !go_mmr;
  wire logic pm_mem_en = int_go && core_req_in.pm_space;
  wire logic dm_mem_en = int_go && !core_req_in.pm_space;
  logic [`OVD_PM_WIDTH-1:0] pm_rdata;
  logic [`OVD_DM_WIDTH-1:0] dm_rdata;

  // (RULE_01) 24-bit program space
  // (RULE_02) Program RAM, depth up to the variant maximum
  ovd_mem #(
    .WIDTH(`OVD_PM_WIDTH),
    .DEPTH(`OVD_PM_WORDS),
    .AW(`OVD_ADDR_WIDTH)
  ) u_pm_mem (
    .clk_sys_in(clk_sys_in),
    .en_in(pm_mem_en),
    .we_in(core_req_in.we),
    .addr_in(core_req_in.addr),
    .wdata_in(core_req_in.wdata),
    .rdata_out(pm_rdata)
  );

  // (RULE_06) 16-bit data space
  ovd_mem #(
    .WIDTH(`OVD_DM_WIDTH),
    .DEPTH(`OVD_DM_WORDS),
    .AW(`OVD_ADDR_WIDTH)
  ) u_dm_mem (
    .clk_sys_in(clk_sys_in),
    .en_in(dm_mem_en),
    .we_in(core_req_in.we),
    .addr_in(core_req_in.addr),
    .wdata_in(core_req_in.wdata[`OVD_DM_WIDTH-1:0]),
    .rdata_out(dm_rdata)
  );

  // --------------------------------------------------------------------
  // Wait-state counter
  // --------------------------------------------------------------------
  wire logic wait_start = req_take && go_ext && !go_refuse;
  logic wait_done;

  ovd_wait u_wait (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .start_in(wait_start),
    .count_in(ext_waits),
    .done_out(wait_done)
  );

  // --------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------
  // Read data passes two synchroniser stages, so the strobe is held two
  // cycles beyond the programmed waits before the pins are sampled.
  always_comb begin
    state_d = state_q;
    case (state_q)
      OVD_ST_IDLE: begin
        if (req_take && go_refuse) begin
          state_d = OVD_ST_REFUSE;
        end else if (req_take && go_ext) begin
          state_d = OVD_ST_EXT;
        end else if (req_take) begin
          state_d = OVD_ST_INT;
        end
      end
      OVD_ST_EXT: begin
        if (wait_done) begin
          state_d = OVD_ST_SYNC;
        end
      end
      OVD_ST_SYNC: begin
        if (sync_cnt_q == 2'h1) begin
          state_d = OVD_ST_DONE;
        end
      end
      OVD_ST_INT: state_d = OVD_ST_IDLE;
      OVD_ST_DONE: state_d = OVD_ST_IDLE;
      OVD_ST_REFUSE: state_d = OVD_ST_IDLE;
      default: state_d = OVD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= OVD_ST_IDLE;
      sync_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      sync_cnt_q <= (state_q == OVD_ST_EXT) ? `OVD_SYNC_STAGES :
                    (sync_cnt_q != 2'h0) ? sync_cnt_q - 2'h1 : 2'h0;
    end
  end

  // Latched request, held for the external cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_q <= '0;
      req_ext_q <= 1'b0;
      req_a13_q <= 1'b0;
    end else if (req_take) begin
      req_q <= core_req_in;
      req_ext_q <= go_ext && !go_refuse;
      req_a13_q <= a13_sel;
    end
  end

  // Pin data: first stage feeds only the second
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_data_s1_q <= '0;
      ext_data_s2_q <= '0;
    end else begin
      ext_data_s1_q <= ext_data_in;
      ext_data_s2_q <= ext_data_s1_q;
    end
  end

  // (RULE_09) Host mode: only 16 data bits are carried
  wire logic [`OVD_PM_WIDTH-1:0] host_data_mask = {{8{!host_mode_q}}, 16'hFFFF};
  wire logic [`OVD_PM_WIDTH-1:0] dm_data_mask = {8'h00, 16'hFFFF};
  wire logic [`OVD_PM_WIDTH-1:0] ext_data_mask =
    req_q.pm_space ? host_data_mask : dm_data_mask;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_rdata_q <= '0;
    end else if ((state_q == OVD_ST_SYNC) && (sync_cnt_q == 2'h1)) begin
      ext_rdata_q <= ext_data_s2_q & ext_data_mask;
    end
  end

  // --------------------------------------------------------------------
  // External bus drive
  // --------------------------------------------------------------------
  wire logic ext_active = (state_q == OVD_ST_EXT) || (state_q == OVD_ST_SYNC);
  // (RULE_09) Host mode address is A0 only
  // (RULE_10) Program overlay address in host mode
  // (RULE_12) Data overlay address in host mode
  wire logic [`OVD_ADDR_WIDTH-1:0] ext_addr = host_mode_q ?
    {13'h0000, req_q.addr[0]} : {req_a13_q, req_q.addr[12:0]};

  // (RULE_03) Overlay cycle on the external bus
  always_comb begin
    ext_bus_out.addr = ext_active ? ext_addr : '0;
    ext_bus_out.pms_n = !(ext_active && req_q.pm_space);
    ext_bus_out.dms_n = !(ext_active && !req_q.pm_space);
    ext_bus_out.rd_n = !(ext_active && !req_q.we);
    ext_bus_out.wr_n = !(ext_active && req_q.we);
    ext_bus_out.data = ext_active ? (req_q.wdata & ext_data_mask) : '0;
    ext_bus_out.data_oe = (ext_active && req_q.we) ? ext_data_mask : '0;
  end

  // --------------------------------------------------------------------
  // Core answer
  // --------------------------------------------------------------------
  wire logic req_mmr_q = !req_q.pm_space && (req_q.addr >= `OVD_MMR_BASE);
  assign core_ack_out = (state_q == OVD_ST_INT) || (state_q == OVD_ST_DONE) ||
                        (state_q == OVD_ST_REFUSE);
  assign core_err_out = (state_q == OVD_ST_REFUSE);
  assign core_rdata_out = (state_q == OVD_ST_DONE) ? ext_rdata_q :
                          (state_q != OVD_ST_INT) ? '0 :
                          req_q.pm_space ? pm_rdata :
                          req_mmr_q ? {8'h00, mmr_rdata_q} : {8'h00, dm_rdata};

  // --------------------------------------------------------------------
  // Register file, Wishbone and core memory-mapped window
  // --------------------------------------------------------------------
  wire logic wb_req = wb_cyc_in && wb_stb_in;
  wire logic wb_wr = wb_req && wb_we_in && !wb_ack_q;
  wire logic wb_hit_ctrl = (wb_adr_in == `OVD_REG_CTRL);
  wire logic wb_hit_wait = (wb_adr_in == `OVD_REG_WAIT);
  wire logic wb_hit_stat = (wb_adr_in == `OVD_REG_STATUS);
  wire logic mmr_wr = req_take && go_mmr && core_req_in.we;
  wire logic [`OVD_DM_WIDTH-1:0] mmr_wdata = core_req_in.wdata[`OVD_DM_WIDTH-1:0];
  wire logic [31:0] ctrl_word = {22'h000000, wait_mode_q, host_mode_q,
                                 data_overlay_select_q, program_overlay_select_q};
  wire logic [31:0] wait_word = {29'h00000000, data_wait_state_count_q};
  wire logic [31:0] stat_word = {29'h00000000, last_ext_q, refused_q,
                                 (state_q != OVD_ST_IDLE)};
  wire logic [31:0] wb_rd_word = wb_hit_ctrl ? ctrl_word :
                                 wb_hit_wait ? wait_word :
                                 wb_hit_stat ? stat_word : 32'h0000_0000;

  // Control writes: Wishbone overrides the core if both land together
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      program_overlay_select_q <= 4'(`OVD_CTRL_RESET);
      data_overlay_select_q <= 4'(`OVD_CTRL_RESET);
      host_mode_q <= 1'b0;
      wait_mode_q <= 1'b0;
      data_wait_state_count_q <= `OVD_WAIT_RESET;
    end else if (wb_wr && wb_hit_ctrl && (|wb_sel_in[1:0])) begin
      if (wb_sel_in[0]) begin
        program_overlay_select_q <= wb_dat_in[`OVD_CTRL_PMOVL_LSB +: 4];
        data_overlay_select_q <= wb_dat_in[`OVD_CTRL_DMOVL_LSB +: 4];
      end
      if (wb_sel_in[1]) begin
        host_mode_q <= wb_dat_in[`OVD_CTRL_HOST_BIT];
        wait_mode_q <= wb_dat_in[`OVD_CTRL_WMODE_BIT];
      end
    end else if (wb_wr && wb_hit_wait && wb_sel_in[0]) begin
      data_wait_state_count_q <= wb_dat_in[2:0];
    end else if (mmr_wr && (mmr_idx == `OVD_MMR_IDX_CTRL)) begin
      program_overlay_select_q <= mmr_wdata[`OVD_CTRL_PMOVL_LSB +: 4];
      data_overlay_select_q <= mmr_wdata[`OVD_CTRL_DMOVL_LSB +: 4];
      host_mode_q <= mmr_wdata[`OVD_CTRL_HOST_BIT];
      wait_mode_q <= mmr_wdata[`OVD_CTRL_WMODE_BIT];
    end else if (mmr_wr && (mmr_idx == `OVD_MMR_IDX_WAIT)) begin
      data_wait_state_count_q <= mmr_wdata[2:0];
    end
  end

  // Refused flag: a new refusal wins over a write-one clear
  wire logic refuse_set = req_take && go_refuse;
  wire logic refuse_clr = wb_wr && wb_hit_stat && wb_sel_in[0] &&
                          wb_dat_in[`OVD_STAT_REFUSED_BIT];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refused_q <= 1'b0;
      last_ext_q <= 1'b0;
    end else begin
      refused_q <= refuse_set | (refused_q & !refuse_clr);
      if (req_take) begin
        last_ext_q <= go_ext && !go_refuse;
      end
    end
  end

  // Core read of the register window; unimplemented words read zero
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mmr_rdata_q <= '0;
    end else if (req_take && go_mmr) begin
      mmr_rdata_q <= (mmr_idx == `OVD_MMR_IDX_CTRL) ? ctrl_word[15:0] :
                     (mmr_idx == `OVD_MMR_IDX_WAIT) ? wait_word[15:0] : 16'h0000;
    end
  end

  // Wishbone answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wb_ack_q <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_q <= wb_req && !wb_ack_q;
      wb_dat_out <= (wb_req && !wb_we_in) ? wb_rd_word : 32'h0000_0000;
    end
  end

  assign wb_ack_out = wb_ack_q;

endmodule

`default_nettype wire

// >>> testbench/ovd_decoder_properties.sv
// Port-level checks of the overlay decoder.
// Assumes ovd_pkg is compiled first; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none

module ovd_decoder_checker
  import ovd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic core_valid_in,
  input wire ovd_pkg::ovd_core_req_t core_req_in,
  input wire logic core_ack_out,
  input wire logic core_err_out,
  input wire ovd_pkg::ovd_ext_bus_t ext_bus_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // ---------------------------------------------
  // Handshakes
  // ---------------------------------------------
  wb_ack_time_a: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("late register ack");
  core_ack_pulse_a: assert property (core_ack_out |=> !core_ack_out)
    else $error("long core ack");
  refuse_ack_a: assert property (core_err_out |-> core_ack_out)
    else $error("error flag without ack");
  onchip_one_a: assert property ($rose(core_valid_in) |=>
    (core_ack_out || !ext_bus_out.dms_n || !ext_bus_out.pms_n))
    else $error("slow on-chip access");

  // ---------------------------------------------
  // External bus
  // ---------------------------------------------
  pm_ovl_time_a: assert property ($fell(ext_bus_out.pms_n) |-> ##3 core_ack_out)
    else $error("slow program overlay");
  dm_wait_span_a: assert property ($fell(ext_bus_out.dms_n) |-> ##[3:18] core_ack_out)
    else $error("bad data wait");
  dm_strobe_hold_a: assert property ($fell(ext_bus_out.dms_n) |-> (!ext_bus_out.dms_n)[*3])
    else $error("data strobe too short");
  pm_window_a: assert property (!ext_bus_out.pms_n |->
    (core_req_in.pm_space && core_req_in.addr[13]))
    else $error("program strobe off window");
  dm_window_a: assert property (!ext_bus_out.dms_n |->
    (!core_req_in.pm_space && !core_req_in.addr[13]))
    else $error("data strobe off window");
  dm_pin_addr_a: assert property (!ext_bus_out.dms_n |-> (ext_bus_out.addr[12:0] ==
    core_req_in.addr[12:0] || ext_bus_out.addr == {13'h0, core_req_in.addr[0]}))
    else $error("bad data pin address");
  fetch_full_a: assert property ((!ext_bus_out.pms_n && core_req_in.fetch) |->
    ext_bus_out.addr[12:0] == core_req_in.addr[12:0])
    else $error("narrow fetch address");
  write_drive_a: assert property (!ext_bus_out.wr_n |-> ext_bus_out.data_oe[15:0] == 16'hFFFF)
    else $error("write not driven");
  read_float_a: assert property (!ext_bus_out.rd_n |-> ext_bus_out.data_oe == 24'h0)
    else $error("read driven");
endmodule

bind ovd_decoder ovd_decoder_checker checker_i (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .core_valid_in(core_valid_in), .core_req_in(core_req_in),
  .core_ack_out(core_ack_out), .core_err_out(core_err_out), .ext_bus_out(ext_bus_out));

`default_nettype wire

// >>> testbench/ovd_ext_mem.sv
// Behavioural external overlay memory on the decoder's pin bus.
// Assumes active-low strobes; a released bus shows the inverse of the last read.
`timescale 1ns/1ps
`default_nettype none

module ovd_ext_mem (
  input wire logic clk_sys_in,
  input wire ovd_pkg::ovd_ext_bus_t bus_in,
  output logic [23:0] data_out
);
  import ovd_pkg::*;
  logic [23:0] mem [0:16383];
  logic [23:0] last_q;
  logic sel_w;
  // Known pattern
  initial begin
    last_q = 24'h0;
    for (int i = 0; i < 16384; i++) mem[i] = {10'h2A5, 14'(i)};
  end
  assign sel_w = !bus_in.dms_n || !bus_in.pms_n;
  always @(posedge clk_sys_in) begin
    if (sel_w && !bus_in.wr_n) mem[bus_in.addr] <= bus_in.data;
    if (sel_w && !bus_in.rd_n) last_q <= mem[bus_in.addr];
  end
  // full data width; a floating bus never repeats
  assign data_out = (sel_w && !bus_in.rd_n) ? mem[bus_in.addr] : ~last_q;
endmodule

`default_nettype wire

// >>> testbench/memory_overlay_decoder_bench.sv
// Table of core accesses, then register and reset cases.
// Assumes the external memory model and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module memory_overlay_decoder_bench;
  import ovd_pkg::*;
  typedef struct packed {
    logic [9:0] ctrl;
    logic [2:0] wt;
    logic [2:0] k;
    logic [13:0] a;
    logic [23:0] wd;
    logic [23:0] rd;
    logic [13:0] pin;
    logic [4:0] cy;
    logic err;
  } ovd_row_t;
  logic clk_sys_in, resetn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, core_valid_in;
  logic core_ack_out, core_err_out, e;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, q32;
  logic [23:0] core_rdata_out, ext_data_in, q;
  logic [13:0] p;
  ovd_core_req_t core_req_in;
  ovd_ext_bus_t ext_bus_out;
  ovd_row_t r;
  int c, error_cnt = 0, check_count = 0;
  // ctrl, wait, {pm,fetch,we}, addr, wdata, rdata, pin addr (3FFF none), cycles, err
  ovd_row_t rows [15] = '{
    '{10'h010, 3'h0, 3'h0, 14'h1234, 24'h0, 24'h5234, 14'h1234, 5'h4, 1'h0},
    '{10'h020, 3'h3, 3'h0, 14'h1234, 24'h0, 24'h7234, 14'h3234, 5'h7, 1'h0},
    '{10'h210, 3'h7, 3'h0, 14'h0005, 24'h0, 24'h4005, 14'h0005, 5'h13, 1'h0},
    '{10'h020, 3'h1, 3'h1, 14'h0042, 24'hCAFE, 24'h0, 14'h2042, 5'h5, 1'h0},
    '{10'h020, 3'h1, 3'h0, 14'h0042, 24'h0, 24'hCAFE, 14'h2042, 5'h5, 1'h0},
    '{10'h002, 3'h0, 3'h6, 14'h2ABC, 24'h0, 24'hA96ABC, 14'h2ABC, 5'h4, 1'h0},
    '{10'h001, 3'h0, 3'h4, 14'h3FFF, 24'h0, 24'hA95FFF, 14'h1FFF, 5'h4, 1'h0},
    '{10'h110, 3'h0, 3'h0, 14'h1233, 24'h0, 24'h4001, 14'h0001, 5'h4, 1'h0},
    '{10'h102, 3'h0, 3'h4, 14'h2ABD, 24'h0, 24'h4001, 14'h0001, 5'h4, 1'h0},
    '{10'h101, 3'h0, 3'h6, 14'h2ABD, 24'h0, 24'h0, 14'h3FFF, 5'h1, 1'h1},
    '{10'h010, 3'h0, 3'h1, 14'h2100, 24'hBEEF, 24'h0, 14'h3FFF, 5'h1, 1'h0},
    '{10'h010, 3'h0, 3'h0, 14'h2100, 24'h0, 24'hBEEF, 14'h3FFF, 5'h1, 1'h0},
    '{10'h000, 3'h0, 3'h5, 14'h2ABC, 24'h654321, 24'h0, 14'h3FFF, 5'h1, 1'h0},
    '{10'h000, 3'h0, 3'h4, 14'h2ABC, 24'h0, 24'h654321, 14'h3FFF, 5'h1, 1'h0},
    '{10'h210, 3'h7, 3'h0, 14'h3FFF, 24'h0, 24'h0210, 14'h3FFF, 5'h1, 1'h0}};

  ovd_decoder uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .core_valid_in(core_valid_in), .core_req_in(core_req_in), .core_ack_out(core_ack_out),
    .core_err_out(core_err_out), .core_rdata_out(core_rdata_out),
    .ext_bus_out(ext_bus_out), .ext_data_in(ext_data_in));
  ovd_ext_mem ext_mem (.clk_sys_in(clk_sys_in), .bus_in(ext_bus_out), .data_out(ext_data_in));

  always #5 clk_sys_in = ~clk_sys_in;

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    wb_cyc_in <= 1'h1;
    wb_stb_in <= 1'h1;
    wb_we_in <= we;
    wb_sel_in <= sel;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'h1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'h0;
    wb_stb_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask

  task automatic acc(input ovd_row_t rw);
    c = -1;
    p = 14'h3FFF;
    core_valid_in <= 1'h1;
    core_req_in <= '{rw.k[2], rw.k[1], rw.k[0], rw.a, rw.wd};
    do begin
      @(posedge clk_sys_in);
      c++;
      if (ext_bus_out.dms_n === 1'h0 || ext_bus_out.pms_n === 1'h0) p = ext_bus_out.addr;
    end while (core_ack_out !== 1'h1);
    q = core_rdata_out;
    e = core_err_out;
    core_valid_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask

  task automatic rst_chk;
    wb(1'h0, 4'hF, 8'h00, 32'h0, q32);
    chk(q32, 32'h0);
    wb(1'h0, 4'hF, 8'h04, 32'h0, q32);
    chk(q32, 32'h7);
  endtask

  task automatic summarize;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end

  initial begin
    clk_sys_in = 1'h0;
    resetn_in = 1'h0;
    {wb_cyc_in, wb_stb_in, wb_we_in, core_valid_in} = 4'h0;
    {wb_adr_in, wb_sel_in, wb_dat_in} = 44'h0;
    core_req_in = '0;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    @(posedge clk_sys_in);
    rst_chk();
    foreach (rows[i]) begin
      r = rows[i];
      wb(1'h1, 4'h3, 8'h00, {22'h0, r.ctrl}, q32);
      wb(1'h1, 4'h1, 8'h04, {29'h0, r.wt}, q32);
      acc(r);
      if (!r.k[0] && !r.err) chk(r.k[2] ? {8'h0, q} : {16'h0, q[15:0]}, {8'h0, r.rd});
      chk({18'h0, p}, {18'h0, r.pin});
      chk(32'(c), {27'h0, r.cy});
      chk({31'h0, e}, {31'h0, r.err});
    end
    wb(1'h0, 4'hF, 8'h08, 32'h0, q32);
    chk(q32 & 32'h2, 32'h2);
    wb(1'h1, 4'hF, 8'h08, 32'h2, q32);
    wb(1'h0, 4'hF, 8'h08, 32'h0, q32);
    chk(q32 & 32'h2, 32'h0);
    wb(1'h1, 4'h1, 8'h00, 32'h3FF, q32);
    wb(1'h0, 4'hF, 8'h00, 32'h0, q32);
    chk(q32, 32'h2FF);
    wb(1'h1, 4'hF, 8'h0C, 32'hFFFFFFFF, q32);
    wb(1'h0, 4'hF, 8'h0C, 32'h0, q32);
    chk(q32, 32'h0);
    // Reset in the middle of a long external access
    wb(1'h1, 4'h3, 8'h00, 32'h10, q32);
    core_valid_in <= 1'h1;
    core_req_in <= '{1'h0, 1'h0, 1'h0, 14'h0010, 24'h0};
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1'h0;
    core_valid_in <= 1'h0;
    @(posedge clk_sys_in);
    chk({30'h0, ext_bus_out.dms_n, ext_bus_out.rd_n}, 32'h3);
    @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    @(posedge clk_sys_in);
    rst_chk();
    summarize();
  end
endmodule

`default_nettype wire
